//--- logic/sdcu_device.sv
// command unit end: nibble-loaded registers and command execution toward cpu and flash
// assumes cpu, ports and flash on clk; flash read data valid in the same cycle as flash_rd
// Notes on behaviour
// - nibble addresses 0-3 load holding register nibbles
// - nibble addresses 4-7 load address register nibbles
// - address 8 loads command, 9 loads mode
// - command 0 writes holding into selected port
// - command 1 programs holding low byte into flash
// - command 2 reads selected port into holding
// - command 3 reads flash byte; cpu halted
// - command 4 reads accumulator; cpu halted
// - command 5 reads flash at pc; halted
// - command 6 reads program counter; cpu halted
// - command 7 halts, command 8 restarts cpu
// - command 9 steps one cpu cycle
// - command a clears program counter; halted
// - command b resets modules; c does nothing
// - command d erases 64-byte page
// - command e erases whole selected partition
// - command f selects auxiliary; halt returns main
// - port access while running; cpu wins collisions
// - host halts for snapshots, restores ports
// - mode 0 four-wire, mode 1 three-wire
`timescale 1ns/1ps
`include "sdcu_map.svh"
module sdcu_device
  import sdcu_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // link to host
  sdcu_link_if.device link,
  // cpu port access
  output logic [3:0] port_sel,
  output logic port_wr,
  output logic [15:0] port_wdata,
  input wire logic [15:0] port_rdata,
  input wire logic cpu_port_active,
  // cpu state and control
  input wire logic [15:0] cpu_acc,
  input wire logic [15:0] cpu_pc,
  output logic cpu_halt,
  output logic cpu_step,
  output logic pc_clear,
  output logic mod_reset,
  // flash
  output logic [11:0] flash_addr,
  output logic [7:0] flash_wdata,
  output logic flash_wr,
  output logic flash_rd,
  input wire logic [7:0] flash_rdata,
  output logic page_erase,
  output logic part_erase,
  output logic aux_part,
  // serial pin mode
  output logic three_wire
);

  dev_regs_t q;
  dev_regs_t d;

  // replace one nibble of a 16-bit word
  function automatic logic [15:0] put_nibble(input logic [15:0] w, input logic [1:0] idx,
                                              input logic [3:0] nib);
    logic [15:0] r;
    r = w;
    r[{idx, 2'b00} +: 4] = nib;
    return r;
  endfunction

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    d = q;
    // strobes last one cycle
    d.port_wr = 1'b0;
    d.flash_wr = 1'b0;
    d.flash_rd = 1'b0;
    d.cpu_step = 1'b0;
    d.pc_clear = 1'b0;
    d.mod_reset = 1'b0;
    d.page_erase = 1'b0;
    d.part_erase = 1'b0;
    d.three_wire = (q.mode == `MODE_THREE_WIRE);
    case (q.st)
      ST_IDLE:
      begin
        // nibbles arriving during execution are dropped so the command stays coherent
        if (link.nibble_valid)
        begin
          if (link.nibble_address <= `NA_HOLD3)
          begin
            d.hold = put_nibble(q.hold, link.nibble_address[1:0], link.nibble_data);
          end
          else if (link.nibble_address <= `NA_ADDR3)
          begin
            d.addr = put_nibble(q.addr, link.nibble_address[1:0], link.nibble_data);
          end
          else if (link.nibble_address == `NA_CMD)
          begin
            d.cmd = link.nibble_data;
            d.st = ST_EXEC; // exactly one execution per command write
            d.busy = 1'b1;
          end
          else if (link.nibble_address == `NA_MODE)
          begin
            d.mode = link.nibble_data;
          end
          // addresses a-f: no register changes
        end
      end
      ST_EXEC:
      begin
        d.st = ST_IDLE;
        d.busy = 1'b0;
        case (q.cmd)
          `CMD_PORT_WR:
          begin
            // the cpu owns the ports in a colliding cycle, so wait it out
            if (cpu_port_active)
            begin
              d.st = ST_EXEC;
              d.busy = 1'b1;
            end
            else
            begin
              d.port_wr = 1'b1;
              d.port_wdata = q.hold;
            end
          end
          `CMD_FLASH_WR:
          begin
            d.flash_wr = 1'b1;
            d.flash_addr = q.addr[11:0];
            d.flash_wdata = q.hold[7:0];
          end
          `CMD_PORT_RD:
          begin
            if (cpu_port_active)
            begin
              d.st = ST_EXEC;
              d.busy = 1'b1;
            end
            else
            begin
              d.hold = port_rdata;
            end
          end
          `CMD_FLASH_RD:
          begin
            d.flash_rd = 1'b1;
            d.flash_addr = q.addr[11:0];
            d.st = ST_FLASH;
            d.busy = 1'b1;
          end
          `CMD_ACC_RD: d.hold = cpu_acc;
          `CMD_PCMEM_RD:
          begin
            d.flash_rd = 1'b1;
            d.flash_addr = cpu_pc[11:0];
            d.st = ST_FLASH;
            d.busy = 1'b1;
          end
          `CMD_PC_RD: d.hold = cpu_pc;
          `CMD_HALT:
          begin
            d.halt = 1'b1;
            d.aux_part = 1'b0; // halt returns selection to main
          end
          `CMD_START: d.halt = 1'b0;
          `CMD_STEP: d.cpu_step = 1'b1; // cpu runs one cycle on this pulse
          `CMD_PC_CLR: d.pc_clear = 1'b1;
          `CMD_MOD_RST: d.mod_reset = 1'b1;
          `CMD_NOP: d.st = ST_IDLE;
          `CMD_PAGE_ERASE:
          begin
            d.page_erase = 1'b1;
            d.flash_addr = {q.addr[11:6], 6'h00};
          end
          `CMD_PART_ERASE: d.part_erase = 1'b1; // size follows aux_part
          `CMD_AUX_SEL: d.aux_part = 1'b1;
          default: d.st = ST_IDLE;
        endcase
      end
      ST_FLASH:
      begin
        // flash answers in the cycle the read strobe is high
        d.hold = {q.hold[15:8], flash_rdata};
        d.st = ST_IDLE;
        d.busy = 1'b0;
      end
      default:
      begin
        d.st = ST_IDLE;
        d.busy = 1'b0;
      end
    endcase
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      q <= '0;
      q.st <= ST_IDLE;
      q.hold <= `RST_HOLD;
      q.addr <= `RST_ADDR;
      q.cmd <= `RST_CMD;
      q.mode <= `RST_MODE;
    end
    else
    begin
      q <= d;
    end
  end

  // ************************************************************
  // outputs, all straight from flops
  // ************************************************************
  assign link.data_holding = q.hold;
  assign link.busy = q.busy;
  assign port_sel = q.addr[3:0];
  assign port_wr = q.port_wr;
  assign port_wdata = q.port_wdata;
  assign cpu_halt = q.halt;
  assign cpu_step = q.cpu_step;
  assign pc_clear = q.pc_clear;
  assign mod_reset = q.mod_reset;
  assign flash_addr = q.flash_addr;
  assign flash_wdata = q.flash_wdata;
  assign flash_wr = q.flash_wr;
  assign flash_rd = q.flash_rd;
  assign page_erase = q.page_erase;
  assign part_erase = q.part_erase;
  assign aux_part = q.aux_part;
  assign three_wire = q.three_wire;

endmodule

//--- logic/sdcu_map.svh
// constants of the serial debug command unit: nibble addresses, command codes, host map
// assumes inclusion by both ends and by the bench; definitions only
`ifndef SDCU_MAP_SVH
`define SDCU_MAP_SVH

// ************************************************************
// nibble addresses
// ************************************************************
`define NA_HOLD0 4'h0
`define NA_HOLD3 4'h3
`define NA_ADDR0 4'h4
`define NA_ADDR3 4'h7
`define NA_CMD 4'h8
`define NA_MODE 4'h9

// ************************************************************
// command codes
// ************************************************************
`define CMD_PORT_WR 4'h0
`define CMD_FLASH_WR 4'h1
`define CMD_PORT_RD 4'h2
`define CMD_FLASH_RD 4'h3
`define CMD_ACC_RD 4'h4
`define CMD_PCMEM_RD 4'h5
`define CMD_PC_RD 4'h6
`define CMD_HALT 4'h7
`define CMD_START 4'h8
`define CMD_STEP 4'h9
`define CMD_PC_CLR 4'ha
`define CMD_MOD_RST 4'hb
`define CMD_NOP 4'hc
`define CMD_PAGE_ERASE 4'hd
`define CMD_PART_ERASE 4'he
`define CMD_AUX_SEL 4'hf

// ************************************************************
// interface mode values and reset values
// ************************************************************
`define MODE_FOUR_WIRE 4'h0
`define MODE_THREE_WIRE 4'h1
`define RST_HOLD 16'h0000
`define RST_ADDR 16'h0000
`define RST_CMD 4'hc
`define RST_MODE 4'h0

// ************************************************************
// host register map (byte addresses)
// ************************************************************
`define HREG_NIBBLE 4'h0
`define HREG_HOLD 4'h4
`define HREG_STATUS 4'h8
`define HNIB_ADDR_LSB 4
`define HNIB_DATA_LSB 0

`endif

//--- logic/sdcu_pkg.sv
// types shared by both ends of the serial debug command unit
// assumes sdcu_map.svh on the include path
package sdcu_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_FLASH = 2'b10
  } dev_state_t;

  typedef struct packed {
    dev_state_t st;
    logic [15:0] hold;
    logic [15:0] addr;
    logic [3:0] cmd;
    logic [3:0] mode;
    logic three_wire;
    logic busy;
    logic halt;
    logic aux_part;
    logic port_wr;
    logic [15:0] port_wdata;
    logic [11:0] flash_addr;
    logic [7:0] flash_wdata;
    logic flash_wr;
    logic flash_rd;
    logic cpu_step;
    logic pc_clear;
    logic mod_reset;
    logic page_erase;
    logic part_erase;
  } dev_regs_t;

  typedef struct packed {
    logic nib_valid;
    logic [3:0] nib_addr;
    logic [3:0] nib_data;
    logic [31:0] rdata;
  } host_regs_t;
endpackage

//--- logic/sdcu_link_if.sv
// link between the programming host end and the command unit end
// assumes both ends on the same clock; the serial framing is abstracted to nibble strobes
`timescale 1ns/1ps
interface sdcu_link_if;
  logic nibble_valid;
  logic [3:0] nibble_address;
  logic [3:0] nibble_data;
  logic [15:0] data_holding;
  logic busy;

  modport host (
    output nibble_valid,
    output nibble_address,
    output nibble_data,
    input data_holding,
    input busy
  );

  modport device (
    input nibble_valid,
    input nibble_address,
    input nibble_data,
    output data_holding,
    output busy
  );
endinterface

//--- logic/sdcu_host.sv
// programming host end: software registers turned into nibble writes on the link
// assumes a plain register port on clk; software polls busy before each command nibble
`timescale 1ns/1ps
`include "sdcu_map.svh"
module sdcu_host
  import sdcu_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // software register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // link to device
  sdcu_link_if.host link
);

  host_regs_t q;
  host_regs_t d;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    d = q;
    d.nib_valid = 1'b0;
    d.rdata = 32'h0000_0000;
    // one software write sends one nibble; halting before snapshots is software's job
    if (reg_wr && reg_addr == `HREG_NIBBLE)
    begin
      d.nib_valid = 1'b1;
      d.nib_addr = reg_wdata[`HNIB_ADDR_LSB +: 4];
      d.nib_data = reg_wdata[`HNIB_DATA_LSB +: 4];
    end
    // read data stand only in the cycle after the strobe
    if (reg_rd)
    begin
      case (reg_addr)
        `HREG_HOLD: d.rdata = {16'h0000, link.data_holding};
        `HREG_STATUS: d.rdata = {31'h0000_0000, link.busy};
        default: d.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign link.nibble_valid = q.nib_valid;
  assign link.nibble_address = q.nib_addr;
  assign link.nibble_data = q.nib_data;
  assign reg_rdata = q.rdata;

endmodule

//--- test/sdcu_chk.sv
// link checker for the command unit
// assumes one clock; sits beside the link interface
`timescale 1ns/1ps
module sdcu_chk (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // link
  input wire logic nibble_valid,
  input wire logic [3:0] nibble_address,
  input wire logic [3:0] nibble_data,
  input wire logic [15:0] data_holding,
  input wire logic busy
);
  // ****
  // helpers
  // ****
  logic cmd_q;
  logic acc;
  // a nibble right after a command nibble is refused even before busy shows
  assign acc = nibble_valid && !busy && !cmd_q;
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      cmd_q <= 1'b0;
    else
      cmd_q <= acc && (nibble_address == 4'h8);
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_hold_nib;
    acc && nibble_address < 4'h4 |=>
      data_holding[{$past(nibble_address[1:0]), 2'b00} +: 4] == $past(nibble_data);
  endproperty
  a_hold_nib: assert property (p_hold_nib) else $error("holding nibble not loaded");
  property p_hold_keep;
    acc && nibble_address < 4'h4 |=> ((data_holding ^ $past(data_holding)) &
      ~(16'hf << {$past(nibble_address[1:0]), 2'b00})) == 16'h0;
  endproperty
  a_hold_keep: assert property (p_hold_keep) else $error("other holding bits moved");
  property p_unused;
    acc && nibble_address > 4'h3 && nibble_address != 4'h8 |=> $stable(data_holding);
  endproperty
  a_unused: assert property (p_unused) else $error("holding changed by other nibble");
  property p_no_exec;
    acc && nibble_address > 4'h9 |=> !busy [*2];
  endproperty
  a_no_exec: assert property (p_no_exec) else $error("unused nibble started work");
  property p_start;
    acc && nibble_address == 4'h8 |=> ##[0:1] busy;
  endproperty
  a_start: assert property (p_start) else $error("command not started");
  property p_cause;
    $rose(busy) |-> cmd_q || $past(cmd_q);
  endproperty
  a_cause: assert property (p_cause) else $error("busy without command");
  property p_len;
    $rose(busy) |-> ##[1:40] !busy;
  endproperty
  a_len: assert property (p_len) else $error("command never ended");
  property p_idle;
    !busy && !nibble_valid && !cmd_q |=> $stable(data_holding);
  endproperty
  a_idle: assert property (p_idle) else $error("holding changed while idle");
  c_cmd: cover property (acc && nibble_address == 4'h8);
  c_done: cover property ($fell(busy));
  c_unused: cover property (acc && nibble_address > 4'h9);
endmodule

//--- test/serial_debug_command_unit_bench.sv
// bench: host end driven by its register port, device end faces it
// assumes the map header on the include path; bench plays cpu, ports and flash
`timescale 1ns/1ps
`include "sdcu_map.svh"
module serial_debug_command_unit_bench;
  import sdcu_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [15:0] port_rdata = 16'h0, cpu_acc = 16'h0, cpu_pc = 16'h0, port_wdata;
  logic cpu_port_active = 1'b0;
  logic [7:0] flash_rdata = 8'h0, flash_wdata, p, acc_p = 8'h0, lw;
  logic [3:0] port_sel;
  logic [11:0] flash_addr, fa;
  logic port_wr, cpu_halt, cpu_step, pc_clear, mod_reset, flash_wr, flash_rd;
  logic page_erase, part_erase, aux_part, three_wire, hl, ax, tw;
  logic rd_seen = 1'b0, busy_seen = 1'b0;
  logic [27:0] pay = 28'h0;
  logic [15:0] h, ad;
  logic [31:0] rd_q[$];
  logic [38:0] ev_q[$];
  logic [3:0] seq[17] = '{0, 1, 2, 7, 3, 4, 5, 6, 9, 'ha, 'hb, 'hc, 'hd, 'hf, 'he, 7, 8};
  int failures = 0;
  int check_count = 0;
  sdcu_link_if link ();
  sdcu_host i_sdcu_host (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link(link));
  sdcu_device i_sdcu_device (.clk(clk), .sys_rst(sys_rst), .link(link), .port_sel(port_sel),
    .port_wr(port_wr), .port_wdata(port_wdata), .port_rdata(port_rdata),
    .cpu_port_active(cpu_port_active), .cpu_acc(cpu_acc), .cpu_pc(cpu_pc), .cpu_halt(cpu_halt),
    .cpu_step(cpu_step), .pc_clear(pc_clear), .mod_reset(mod_reset), .flash_addr(flash_addr),
    .flash_wdata(flash_wdata), .flash_wr(flash_wr), .flash_rd(flash_rd),
    .flash_rdata(flash_rdata), .page_erase(page_erase), .part_erase(part_erase),
    .aux_part(aux_part), .three_wire(three_wire));
  sdcu_chk i_sdcu_chk (.clk(clk), .sys_rst(sys_rst), .nibble_valid(link.nibble_valid),
    .nibble_address(link.nibble_address), .nibble_data(link.nibble_data),
    .data_holding(link.data_holding), .busy(link.busy));
  // ****
  // clock, watchdog, compares
  // ****
  initial
  begin
    forever #5 clk = ~clk;
  end
  initial
  begin
    #400000;
    failures++;
    complete_run();
  end
  task automatic chk_rd(input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e)
    begin
      failures++;
      $display("[ERR] reg_rdata exp %h got %h", e, s);
    end
  endtask
  task automatic chk_ev(input logic [38:0] e, input logic [38:0] s);
    check_count++;
    if (s !== e)
    begin
      failures++;
      $display("[ERR] command result exp %h got %h", e, s);
    end
  endtask
  // results sampled mid-cycle, well clear of the edge that launched them
  assign p = {port_wr, flash_wr, flash_rd, cpu_step, pc_clear, mod_reset, page_erase, part_erase};
  always @(negedge clk)
  begin
    if (rd_seen)
      chk_rd(rd_q.pop_front(), reg_rdata);
    if (p[7])
      pay = {port_sel, 8'h0, port_wdata};
    else if (p[6] || p[5] || p[1])
      pay = {flash_wdata, 4'h0, flash_addr, 4'h0};
    acc_p = acc_p | p;
    if (busy_seen && !link.busy)
    begin
      chk_ev(ev_q.pop_front(), {acc_p, cpu_halt, aux_part, three_wire, pay});
      acc_p = 8'h0;
      pay = 28'h0;
    end
    rd_seen = reg_rd;
    busy_seen = link.busy;
  end
  // ****
  // drivers
  // ****
  task automatic bus(input logic [3:0] a, input logic [31:0] d, input logic w);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus(a, 32'h0, 1'b0);
  endtask
  task automatic nib(input logic [3:0] a, input logic [3:0] d);
    bus(`HREG_NIBBLE, {24'h0, a, d}, 1'b1);
  endtask
  // the bench keeps its own copy of every register to predict the result
  task automatic cmd(input logic [3:0] c);
    logic [31:0] r1;
    logic [31:0] r2;
    logic [27:0] ey;
    r1 = $urandom;
    r2 = $urandom;
    port_rdata <= r1[15:0];
    cpu_acc <= r1[31:16];
    cpu_pc <= r2[15:0];
    flash_rdata <= r2[23:16];
    // both port commands meet a busy cpu, so the collision wait is seen on reads and writes
    cpu_port_active <= (c inside {`CMD_PORT_WR, `CMD_PORT_RD});
    ey = (c == `CMD_PORT_WR) ? {ad[3:0], 8'h0, h} : 28'h0;
    fa = (c == `CMD_PCMEM_RD) ? r2[11:0] : ad[11:0];
    if (c == `CMD_PAGE_ERASE)
      fa = {ad[11:6], 6'h0};
    if (c == `CMD_FLASH_WR)
      lw = h[7:0];
    if (c inside {`CMD_FLASH_WR, `CMD_FLASH_RD, `CMD_PCMEM_RD, `CMD_PAGE_ERASE})
      ey = {lw, 4'h0, fa, 4'h0};
    if (c == `CMD_PORT_RD)
      h = r1[15:0];
    if (c == `CMD_FLASH_RD || c == `CMD_PCMEM_RD)
      h[7:0] = r2[23:16];
    if (c == `CMD_ACC_RD)
      h = r1[31:16];
    if (c == `CMD_PC_RD)
      h = r2[15:0];
    if (c == `CMD_HALT)
      {hl, ax} = 2'b10; // halt also returns flash accesses to the main partition
    if (c == `CMD_START)
      hl = 1'b0;
    if (c == `CMD_AUX_SEL)
      ax = 1'b1;
    ev_q.push_back({8'h80 >> (c == 1) + 2 * (c == 3 || c == 5) + 3 * (c == 9) + 4 * (c == 10)
      + 5 * (c == 11) + 6 * (c == 13) + 7 * (c == 14) + 8 * (c inside {2, 4, 6, 7, 8, 12, 15}),
      hl, ax, tw, ey});
    nib(`NA_CMD, c);
    repeat (4) @(posedge clk);
    if (c inside {`CMD_PORT_WR, `CMD_PORT_RD})
      rd(`HREG_STATUS, 32'h1);
    cpu_port_active <= 1'b0;
    // busy is looked at mid-cycle; a command that never ends counts as a mismatch
    for (int i = 0; i < 60 && link.busy !== 1'b0; i++)
      @(negedge clk);
    if (link.busy !== 1'b0)
    begin
      failures++;
      $display("[ERR] busy exp 0 got %b", link.busy);
    end
    rd(`HREG_HOLD, {16'h0, h});
  endtask
  // ****
  // main sequence
  // ****
  task automatic complete_run();
    if (failures == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    logic [31:0] r;
    void'($urandom(32'h508e));
    {h, ad, lw, hl, ax, tw} = '0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`HREG_HOLD, 32'h0);
    rd(4'hc, 32'h0);
    for (int i = 0; i < 16; i++)
    begin
      r = $urandom;
      if (i != 8)
        nib(i[3:0], r[3:0]);
      if (i < 4)
        h[i * 4 +: 4] = r[3:0];
      else if (i < 8)
        ad[(i - 4) * 4 +: 4] = r[3:0];
      else if (i == 9)
        tw = (r[3:0] == `MODE_THREE_WIRE);
    end
    rd(`HREG_HOLD, {16'h0, h});
    foreach (seq[k])
    begin
      r = $urandom;
      for (int j = 0; j < 4; j++)
        nib(4'h4 + j[3:0], r[j * 4 +: 4]);
      ad = r[15:0];
      tw = (k > 7);
      nib(`NA_MODE, {3'h0, tw});
      // the sequence halts before snapshot reads, flash reads and erases, but after the flash write
      cmd(seq[k]);
    end
    complete_run();
  end
endmodule
